// [core/iopg_map.svh]
// What this block does
// - input port read returns 1 for high pins, 0 for low pins
// - writes to input port registers are ignored entirely
// - pulldown select bit 0 enables pulldown, 1 disables it
// - pulldown select is 4-bit read/write at 0x66, bit n to pin n
// - power-on and watchdog reset clear pulldown select to zero
// - chip-enable reset and clock stop keep pulldown select bits
// - input ports stay inputs always; halt keeps all port state
// - clock stop gates floating input paths except second port bits 3,2,0
// - output port drives pins from latch; 1 not driven, 0 low
// - output is open drain: 1 releases pin, 0 pulls low
// - output port read returns latch contents, not pin levels
// - power-on and watchdog reset clear output latch, still driven
// - chip-enable reset, clock stop and halt keep output latch
`ifndef IOPG_MAP_SVH
`define IOPG_MAP_SVH
// register index 0x66 is not word aligned, so its byte address is 4x it
`define IOPG_IDX_PULLDOWN 12'h066
`define IOPG_OFS_PULLDOWN 12'h198
`define IOPG_OFS_PD_PORT 12'h070
`define IOPG_OFS_IN_A 12'h074
`define IOPG_OFS_IN_C 12'h078
`define IOPG_OFS_OUT_PORT 12'h07c
`define IOPG_RST_PULLDOWN 4'h0
`define IOPG_RST_OUT_LATCH 4'h0
`define IOPG_GATE_KEEP_A 4'hd
`endif

// [core/iopg_pkg.sv]
package iopg_pkg;
	typedef logic [3:0] iopg_nib_t;
	typedef enum logic [2:0] {
		IOPG_SEL_NONE = 3'b000,
		IOPG_SEL_PULLDOWN = 3'b001,
		IOPG_SEL_PD_PORT = 3'b010,
		IOPG_SEL_IN_A = 3'b011,
		IOPG_SEL_IN_C = 3'b100,
		IOPG_SEL_OUT = 3'b101
	} iopg_sel_t;
endpackage : iopg_pkg

// [core/iopg_top.sv]
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "iopg_map.svh"
module iopg_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic watchdog_stack_reset,
	input wire logic clock_stop,
	input wire logic halt,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] pulldown_input_port,
	input wire logic [3:0] plain_input_port_a,
	input wire logic [3:0] plain_input_port_c,
	input wire logic [3:0] open_drain_output_port_in,
	output logic [3:0] open_drain_output_port_out,
	output logic [3:0] open_drain_output_port_oe,
	output logic [3:0] pulldown_enable
);
	// rst_n is power-on reset; chip-enable reset does not reach this block
	iopg_pkg::iopg_nib_t pulldown_reg;
	iopg_pkg::iopg_nib_t latch_reg;
	iopg_pkg::iopg_nib_t sync_d1_reg, sync_d2_reg;
	iopg_pkg::iopg_nib_t sync_a1_reg, sync_a2_reg;
	iopg_pkg::iopg_nib_t sync_c1_reg, sync_c2_reg;
	iopg_pkg::iopg_nib_t gate_d, gate_a, gate_c;
	iopg_pkg::iopg_sel_t sel;
	logic hard_reset;
	logic access;
	logic wr_ok;
	logic [31:0] prdata_next;

	assign hard_reset = !rst_n || watchdog_stack_reset;
	assign access = psel && penable && !pready;

	always_comb begin
		case (paddr)
			`IOPG_OFS_PULLDOWN: sel = iopg_pkg::IOPG_SEL_PULLDOWN;
			`IOPG_OFS_PD_PORT: sel = iopg_pkg::IOPG_SEL_PD_PORT;
			`IOPG_OFS_IN_A: sel = iopg_pkg::IOPG_SEL_IN_A;
			`IOPG_OFS_IN_C: sel = iopg_pkg::IOPG_SEL_IN_C;
			`IOPG_OFS_OUT_PORT: sel = iopg_pkg::IOPG_SEL_OUT;
			default: sel = iopg_pkg::IOPG_SEL_NONE;
		endcase
	end

	// halt freezes register writes; the bus still answers
	assign wr_ok = access && pwrite && pstrb[0] && !halt;

	// synchronisers, frozen in halt
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_d1_reg <= 4'h0;
			sync_d2_reg <= 4'h0;
			sync_a1_reg <= 4'h0;
			sync_a2_reg <= 4'h0;
			sync_c1_reg <= 4'h0;
			sync_c2_reg <= 4'h0;
		end else if (!halt) begin
			sync_d1_reg <= pulldown_input_port;
			sync_d2_reg <= sync_d1_reg;
			sync_a1_reg <= plain_input_port_a;
			sync_a2_reg <= sync_a1_reg;
			sync_c1_reg <= plain_input_port_c;
			sync_c2_reg <= sync_c1_reg;
		end
	end

	// clock stop blocks floating inputs; a-port bits 3,2,0 stay open
	assign gate_d = clock_stop ? 4'h0 : sync_d2_reg;
	assign gate_a = clock_stop ? (sync_a2_reg & `IOPG_GATE_KEEP_A)
		: sync_a2_reg;
	assign gate_c = clock_stop ? 4'h0 : sync_c2_reg;

	always_ff @(posedge clk) begin
		if (hard_reset) begin
			pulldown_reg <= `IOPG_RST_PULLDOWN;
		end else if (wr_ok && sel == iopg_pkg::IOPG_SEL_PULLDOWN) begin
			pulldown_reg <= pwdata[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (hard_reset) begin
			latch_reg <= `IOPG_RST_OUT_LATCH;
		end else if (wr_ok && sel == iopg_pkg::IOPG_SEL_OUT) begin
			latch_reg <= pwdata[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pulldown_enable <= 4'hf;
			open_drain_output_port_out <= 4'h0;
			open_drain_output_port_oe <= 4'hf;
		end else begin
			pulldown_enable <= ~pulldown_reg;
			open_drain_output_port_out <= 4'h0;
			open_drain_output_port_oe <= ~latch_reg;
		end
	end

	always_comb begin
		prdata_next = 32'h0000_0000;
		case (sel)
			iopg_pkg::IOPG_SEL_PULLDOWN: prdata_next[3:0] = pulldown_reg;
			iopg_pkg::IOPG_SEL_PD_PORT: prdata_next[3:0] = gate_d;
			iopg_pkg::IOPG_SEL_IN_A: prdata_next[3:0] = gate_a;
			iopg_pkg::IOPG_SEL_IN_C: prdata_next[3:0] = gate_c;
			iopg_pkg::IOPG_SEL_OUT: prdata_next[3:0] = latch_reg;
			default: prdata_next = 32'h0000_0000;
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access;
			pslverr <= access && sel == iopg_pkg::IOPG_SEL_NONE;
			if (access && !pwrite) begin
				prdata <= prdata_next;
			end
		end
	end

	// input port writes fall to no register

	pd_reset_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		watchdog_stack_reset |=> pulldown_reg == 4'h0)
		else $error("pulldown select not cleared");

	latch_reset_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		watchdog_stack_reset |=> latch_reg == 4'h0 ##1
		open_drain_output_port_oe == 4'hf)
		else $error("output latch not cleared");

	wd_pd_en_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		watchdog_stack_reset |=> ##1 pulldown_enable == 4'hf)
		else $error("pulldowns not reconnected");

	pd_drive_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		rst_n |=> pulldown_enable == ~$past(pulldown_reg))
		else $error("pulldown enable wrong");

	od_low_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		open_drain_output_port_out == 4'h0)
		else $error("open drain drives high");

	od_drive_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		rst_n |=> open_drain_output_port_oe == ~$past(latch_reg))
		else $error("open drain drive wrong");

	out_write_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr_ok && sel == iopg_pkg::IOPG_SEL_OUT && !watchdog_stack_reset
		|=> latch_reg == $past(pwdata[3:0]))
		else $error("latch write lost");

	pd_write_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr_ok && sel == iopg_pkg::IOPG_SEL_PULLDOWN && !watchdog_stack_reset
		|=> pulldown_reg == $past(pwdata[3:0]))
		else $error("pulldown select write lost");

	halt_keep_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		halt && !watchdog_stack_reset
		|=> $stable(latch_reg) && $stable(pulldown_reg))
		else $error("state changed in halt");

	halt_sync_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		halt |=> $stable(sync_d2_reg) && $stable(sync_a2_reg) &&
		$stable(sync_c2_reg))
		else $error("input state changed in halt");

	in_write_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access && pwrite && sel == iopg_pkg::IOPG_SEL_IN_A &&
		!watchdog_stack_reset
		|=> $stable(latch_reg) && $stable(pulldown_reg))
		else $error("input write changed state");

	pd_port_write_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access && pwrite && sel == iopg_pkg::IOPG_SEL_PD_PORT &&
		!watchdog_stack_reset
		|=> $stable(latch_reg) && $stable(pulldown_reg))
		else $error("pulldown port write changed state");

	c_write_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access && pwrite && sel == iopg_pkg::IOPG_SEL_IN_C &&
		!watchdog_stack_reset
		|=> $stable(latch_reg) && $stable(pulldown_reg))
		else $error("port c write changed state");

	bad_write_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access && pwrite && sel == iopg_pkg::IOPG_SEL_NONE &&
		!watchdog_stack_reset
		|=> $stable(latch_reg) && $stable(pulldown_reg))
		else $error("unmapped write changed state");

	no_strobe_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access && pwrite && !pstrb[0] && !watchdog_stack_reset
		|=> $stable(latch_reg) && $stable(pulldown_reg))
		else $error("write without strobe landed");

	out_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access && !pwrite && sel == iopg_pkg::IOPG_SEL_OUT
		|=> prdata[3:0] == $past(latch_reg))
		else $error("output read not latch");

	pd_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access && !pwrite && sel == iopg_pkg::IOPG_SEL_PULLDOWN
		|=> prdata[3:0] == $past(pulldown_reg))
		else $error("pulldown select read wrong");

	in_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access && !pwrite && sel == iopg_pkg::IOPG_SEL_IN_C && !clock_stop
		|=> prdata[3:0] == $past(sync_c2_reg))
		else $error("input read wrong");

	a_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access && !pwrite && sel == iopg_pkg::IOPG_SEL_IN_A && !clock_stop
		|=> prdata[3:0] == $past(sync_a2_reg))
		else $error("port a read wrong");

	d_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access && !pwrite && sel == iopg_pkg::IOPG_SEL_PD_PORT &&
		!clock_stop
		|=> prdata[3:0] == $past(sync_d2_reg))
		else $error("pulldown port read wrong");

	prdata_hi_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		prdata[31:4] == 28'h0)
		else $error("read data upper bits set");

	read_hold_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!(access && !pwrite) |=> $stable(prdata))
		else $error("read data changed without read");

	stop_gate_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		clock_stop |-> gate_d == 4'h0 && gate_a[1] == 1'b0 &&
		gate_c == 4'h0)
		else $error("clock stop gating wrong");

	stop_pass_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		clock_stop |-> gate_a[3:2] == sync_a2_reg[3:2] &&
		gate_a[0] == sync_a2_reg[0])
		else $error("clock stop blocked an excepted bit");

	run_pass_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!clock_stop |-> gate_d == sync_d2_reg && gate_a == sync_a2_reg &&
		gate_c == sync_c2_reg)
		else $error("input gated while running");

	sync_path_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!halt ##1 !halt |=> sync_d2_reg == $past(pulldown_input_port, 2))
		else $error("synchroniser depth wrong");

	sync_a_path_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!halt ##1 !halt |=> sync_a2_reg == $past(plain_input_port_a, 2))
		else $error("port a synchroniser depth wrong");

	sync_c_path_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!halt ##1 !halt |=> sync_c2_reg == $past(plain_input_port_c, 2))
		else $error("port c synchroniser depth wrong");

	stop_keep_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		clock_stop && !wr_ok && !watchdog_stack_reset
		|=> $stable(pulldown_reg))
		else $error("pulldown select lost in clock stop");

	stop_latch_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		clock_stop && !wr_ok && !watchdog_stack_reset
		|=> $stable(latch_reg))
		else $error("output latch lost in clock stop");

	ready_answer_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access |=> pready)
		else $error("access not answered");

	ready_pulse_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		pready |=> !pready)
		else $error("ready longer than one cycle");

	halt_bus_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		halt && access |=> pready)
		else $error("bus stalled in halt");

	err_map_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		access && sel == iopg_pkg::IOPG_SEL_NONE |=> pslverr && pready)
		else $error("unmapped access without error");

	err_only_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		pslverr |-> pready)
		else $error("error without ready");

	sel_decode_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		paddr == `IOPG_OFS_PULLDOWN |-> sel == iopg_pkg::IOPG_SEL_PULLDOWN)
		else $error("pulldown select not decoded");

	out_decode_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		paddr == `IOPG_OFS_OUT_PORT |-> sel == iopg_pkg::IOPG_SEL_OUT)
		else $error("output port not decoded");

	rd_cov_c: cover property (@(posedge clk) access && !pwrite);
	wr_cov_c: cover property (@(posedge clk) wr_ok);
	err_cov_c: cover property (@(posedge clk) pslverr);
	stop_cov_c: cover property (@(posedge clk) clock_stop && access);
	halt_cov_c: cover property (@(posedge clk) halt && access && pwrite);
endmodule : iopg_top

// [verification/iopg_ext_model.sv]
`timescale 1ns/10ps
module iopg_ext_model (
	input wire logic clk,
	input wire logic [3:0] od_oe,
	input wire logic [3:0] pd_en,
	input wire logic drive_on,
	input wire logic [3:0] drive_val,
	output logic [3:0] od_pin,
	output logic [3:0] pd_pin
);
	logic [3:0] drift = 4'h5;
	always @(posedge clk) drift <= ~drift;
	// external pull-up lifts every released pin
	assign od_pin = ~od_oe;
	// an undriven pin wanders unless its pulldown holds it low
	assign pd_pin = drive_on ? drive_val : (drift & ~pd_en);
endmodule : iopg_ext_model

// [verification/input_output_port_group_tb.sv]
`timescale 1ns/10ps
module input_output_port_group_tb;
	logic clk = 0, rst_n = 0, wd = 0, cs = 0, hlt = 0, drv = 1;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [3:0] pa = '0, pc = '0, dv = '0, od_pin, od_out, od_oe, pd_en, pd_pin;
	int miscompares = 0, checked = 0, cyc = 0;
	iopg_pkg::iopg_nib_t rd, v, w;
	always #10 clk = ~clk;
	iopg_ext_model iopg_ext_model_i (.clk(clk), .od_oe(od_oe), .pd_en(pd_en),
		.drive_on(drv), .drive_val(dv), .od_pin(od_pin), .pd_pin(pd_pin));
	iopg_top iopg_top_i (.clk(clk), .rst_n(rst_n), .watchdog_stack_reset(wd),
		.clock_stop(cs), .halt(hlt), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pulldown_input_port(pd_pin), .plain_input_port_a(pa),
		.plain_input_port_c(pc), .open_drain_output_port_in(od_pin),
		.open_drain_output_port_out(od_out),
		.open_drain_output_port_oe(od_oe), .pulldown_enable(pd_en));
	task automatic chk(string n, iopg_pkg::iopg_nib_t s,
		iopg_pkg::iopg_nib_t e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// expected input read: clock stop keeps only the excepted bits
	function automatic iopg_pkg::iopg_nib_t exp_in(logic stop,
		iopg_pkg::iopg_nib_t p, iopg_pkg::iopg_nib_t keep);
		return stop ? (p & keep) : p;
	endfunction : exp_in
	task automatic apb(logic wr, logic [11:0] a, iopg_pkg::iopg_nib_t d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {28'h0, d};
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata[3:0];
		err = pslverr;
		if (n >= 20) miscompares++;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		void'($urandom(77320));
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		apb(1'h0, 12'h198, 4'h0);
		chk("select", rd, 4'h0);
		chk("pd_en", pd_en, 4'hf);
		apb(1'h0, 12'h07c, 4'h0);
		chk("latch", rd, 4'h0);
		chk("od_pin", od_pin, 4'h0);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			v = 4'($urandom);
			w = 4'($urandom);
			pa <= 4'($urandom);
			pc <= 4'($urandom);
			dv <= 4'($urandom);
			apb(1'h1, 12'h198, v);
			apb(1'h1, 12'h07c, w);
			apb(1'h1, 12'h074, ~v);
			apb(1'h0, 12'h198, 4'h0);
			chk("select", rd, v);
			chk("pd_en", pd_en, ~v);
			apb(1'h0, 12'h07c, 4'h0);
			chk("latch", rd, w);
			chk("od_pin", od_pin, w);
			chk("od_out", od_out, 4'h0);
			apb(1'h0, 12'h070, 4'h0);
			chk("pd_port", rd, dv);
			apb(1'h0, 12'h074, 4'h0);
			chk("port_a", rd, exp_in(1'b0, pa, 4'hd));
			apb(1'h0, 12'h078, 4'h0);
			chk("port_c", rd, pc);
		end
		drv <= 1'h0;
		apb(1'h1, 12'h198, 4'h0);
		repeat (2) apb(1'h0, 12'h070, 4'h0);
		chk("pulled", rd, 4'h0);
		$display("random test done");
		apb(1'h1, 12'h198, 4'h9);
		apb(1'h1, 12'h07c, 4'h6);
		drv <= 1'h1;
		dv <= 4'hf;
		pa <= 4'hf;
		cs <= 1'h1;
		repeat (2) apb(1'h0, 12'h074, 4'h0);
		chk("gated_a", rd, exp_in(1'b1, 4'hf, 4'hd));
		apb(1'h0, 12'h070, 4'h0);
		chk("gated_pd", rd, exp_in(1'b1, 4'hf, 4'h0));
		apb(1'h0, 12'h198, 4'h0);
		chk("select", rd, 4'h9);
		cs <= 1'h0;
		hlt <= 1'h1;
		apb(1'h1, 12'h07c, 4'h3);
		hlt <= 1'h0;
		apb(1'h0, 12'h07c, 4'h0);
		chk("latch", rd, 4'h6);
		@(posedge clk) wd <= 1'h1;
		@(posedge clk) wd <= 1'h0;
		apb(1'h0, 12'h198, 4'h0);
		chk("select", rd, 4'h0);
		apb(1'h0, 12'h07c, 4'h0);
		chk("latch", rd, 4'h0);
		chk("od_oe", od_oe, 4'hf);
		apb(1'h0, 12'h080, 4'h0);
		chk("slverr", {3'h0, err}, 4'h1);
		$display("mode test done");
		summarize();
	end
endmodule : input_output_port_group_tb
